// ---- rtl/cbu_top.sv ----
// Compare, branch and bit-field execution unit
`timescale 1ns/1ps
`default_nettype none
module cbu_top (
    // Clock and reset
    input wire logic CLK_IN,
    input wire logic RESETN_IN,
    // Operation request from decode
    input wire logic OP_VALID_IN,
    input wire cbu_pkg::cbu_op_e OP_CODE_IN,
    input wire logic [31:0] SRC1_IN,
    input wire logic [31:0] SRC2_IN,
    input wire logic [31:0] SRC3_IN,
    input wire logic [4:0] DEST_REG_IN,
    input wire logic [2:0] COND_SEL_IN,
    // Instruction pointer and addressing
    input wire logic [31:0] IP_IN,
    input wire logic [31:0] NEXT_IP_IN,
    input wire logic [31:0] DISP_IN,
    input wire logic [31:0] EA_IN,
    input wire logic EA_IP_REL_IN,
    // Register write-back
    output logic RES_WE_OUT,
    output logic [4:0] RES_REG_OUT,
    output logic [31:0] RES_DATA_OUT,
    // Branch redirect
    output logic BRANCH_OUT,
    output logic [31:0] TARGET_IP_OUT,
    // Arithmetic controls condition code
    output logic [2:0] CC_OUT
);
    cbu_ops_if ops ();

    logic [2:0] cc_q;
    logic [2:0] cc_d;
    logic we_q;
    logic we_d;
    logic [4:0] reg_q;
    logic [4:0] reg_d;
    logic [31:0] data_q;
    logic [31:0] data_d;
    logic take_q;
    logic take_d;
    logic [31:0] tgt_q;
    logic [31:0] tgt_d;
    logic [31:0] disp_target;
    logic [31:0] ext_target;

    cbu_compare u_compare (
        .ops(ops)
    );

    cbu_bitfield u_bitfield (
        .ops(ops)
    );

    // Operands go straight to the datapath slices
    assign ops.opa = SRC1_IN;
    assign ops.opb = SRC2_IN;
    assign ops.opc = SRC3_IN;
    assign ops.is_signed = OP_CODE_IN inside {cbu_pkg::OP_CMPI,
        cbu_pkg::OP_CONCMPI, cbu_pkg::OP_CMPINCI, cbu_pkg::OP_CMPDECI,
        cbu_pkg::OP_CMP_BRANCH_I};

    // Branch targets: pointer-relative or effective address
    assign disp_target = IP_IN + DISP_IN;
    assign ext_target = EA_IP_REL_IN ? disp_target : EA_IN;

    // Next state of code, write-back and redirect
    always_comb
    begin
        cc_d = cc_q;
        we_d = 1'b0;
        reg_d = DEST_REG_IN;
        data_d = cbu_pkg::WORD_ZERO;
        take_d = 1'b0;
        tgt_d = disp_target;
        if (OP_VALID_IN)
        begin
            unique case (OP_CODE_IN)
                cbu_pkg::OP_EXTRACT:
                begin
                    we_d = 1'b1;
                    data_d = ops.extract_val;
                end
                cbu_pkg::OP_MODIFY:
                begin
                    we_d = 1'b1;
                    data_d = ops.merge_val;
                end
                cbu_pkg::OP_SCANBYTE:
                begin
                    cc_d = ops.scan_cc;
                end
                cbu_pkg::OP_LOAD_SHORT:
                begin
                    we_d = 1'b1;
                    data_d = ops.sext_val;
                end
                cbu_pkg::OP_CMPI, cbu_pkg::OP_CMPO:
                begin
                    cc_d = ops.cmp_cc;
                end
                cbu_pkg::OP_CONCMPI, cbu_pkg::OP_CONCMPO:
                begin
                    if (!cc_q[cbu_pkg::CC_SKIP_BIT])
                    begin
                        cc_d = ops.cmp_cc;
                    end
                end
                cbu_pkg::OP_CMPINCI, cbu_pkg::OP_CMPINCO:
                begin
                    cc_d = ops.cmp_cc;
                    we_d = 1'b1;
                    data_d = SRC2_IN + cbu_pkg::WORD_ONE;
                end
                cbu_pkg::OP_CMPDECI, cbu_pkg::OP_CMPDECO:
                begin
                    cc_d = ops.cmp_cc;
                    we_d = 1'b1;
                    data_d = SRC2_IN - cbu_pkg::WORD_ONE;
                end
                cbu_pkg::OP_BRANCH:
                begin
                    take_d = 1'b1;
                end
                cbu_pkg::OP_JUMP_EXTENDED:
                begin
                    take_d = 1'b1;
                    tgt_d = ext_target;
                end
                cbu_pkg::OP_BRANCH_LINK:
                begin
                    take_d = 1'b1;
                    we_d = 1'b1;
                    reg_d = cbu_pkg::LINK_GLOBAL_REG;
                    data_d = NEXT_IP_IN;
                end
                cbu_pkg::OP_JUMP_EXTENDED_LINK:
                begin
                    take_d = 1'b1;
                    tgt_d = ext_target;
                    we_d = 1'b1;
                    data_d = NEXT_IP_IN;
                end
                cbu_pkg::OP_BRANCH_IF:
                begin
                    take_d = cbu_pkg::cbu_cond_match(cc_q,
                                                     COND_SEL_IN);
                end
                cbu_pkg::OP_CMP_BRANCH_I, cbu_pkg::OP_CMP_BRANCH_O:
                begin
                    cc_d = ops.cmp_cc;
                    take_d = cbu_pkg::cbu_cond_match(ops.cmp_cc, COND_SEL_IN);
                end
                cbu_pkg::OP_CHECK_BIT_BRANCH:
                begin
                    cc_d = ops.bit_cc;
                    take_d = cbu_pkg::cbu_cond_match(ops.bit_cc, COND_SEL_IN);
                end
                cbu_pkg::OP_TEST:
                begin
                    we_d = 1'b1;
                    data_d = cbu_pkg::cbu_cond_match(cc_q, COND_SEL_IN)
                             ? cbu_pkg::WORD_ONE
                             : cbu_pkg::WORD_ZERO;
                end
                default:
                begin
                    we_d = 1'b0;
                end
            endcase
        end
    end

    // Condition code of the arithmetic controls
    always_ff @(posedge CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            cc_q <= cbu_pkg::CC_RESET;
        end
        else
        begin
            cc_q <= cc_d;
        end
    end

    // Register write-back stage
    always_ff @(posedge CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            we_q <= 1'b0;
            reg_q <= cbu_pkg::REG_RESET;
            data_q <= cbu_pkg::WORD_ZERO;
        end
        else
        begin
            we_q <= we_d;
            reg_q <= reg_d;
            data_q <= data_d;
        end
    end

    // Redirect stage; target holds until the next taken branch
    always_ff @(posedge CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            take_q <= 1'b0;
            tgt_q <= cbu_pkg::WORD_ZERO;
        end
        else
        begin
            take_q <= take_d;
            if (take_d)
            begin
                tgt_q <= tgt_d;
            end
        end
    end

    assign CC_OUT = cc_q;
    assign RES_WE_OUT = we_q;
    assign RES_REG_OUT = reg_q;
    assign RES_DATA_OUT = data_q;
    assign BRANCH_OUT = take_q;
    assign TARGET_IP_OUT = tgt_q;

    // Checks on the unit's own outputs
    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (!RESETN_IN);

    sequence s_op(cbu_pkg::cbu_op_e k);
        OP_VALID_IN && OP_CODE_IN == k;
    endsequence

    sequence s_wrote_reg(logic [4:0] r);
        RES_WE_OUT && RES_REG_OUT == r;
    endsequence

    property p_extract_zero;
        s_op(cbu_pkg::OP_EXTRACT) ##0 (SRC2_IN[5:0] < 6'h20) |=>
            RES_WE_OUT && (RES_DATA_OUT >> $past(SRC2_IN[5:0])) == 32'h0;
    endproperty
    a_extract_zero: assert property (p_extract_zero)
        else $error("extract left bits above the field");

    property p_merge;
        s_op(cbu_pkg::OP_MODIFY) |=>
            ((RES_DATA_OUT ^ $past(SRC3_IN)) & ~$past(SRC1_IN)) == 32'h0
            && ((RES_DATA_OUT ^ $past(SRC2_IN)) & $past(SRC1_IN)) == 32'h0;
    endproperty
    a_merge: assert property (p_merge)
        else $error("merge touched unmasked bits or missed masked ones");

    property p_scan_low;
        s_op(cbu_pkg::OP_SCANBYTE) ##0 (SRC1_IN[7:0] == SRC2_IN[7:0]) |=>
            CC_OUT == cbu_pkg::CC_EQUAL;
    endproperty
    a_scan_low: assert property (p_scan_low)
        else $error("byte scan missed an equal lane");

    property p_sext;
        s_op(cbu_pkg::OP_LOAD_SHORT) |=>
            $signed(RES_DATA_OUT) == $signed($past(SRC1_IN[15:0]));
    endproperty
    a_sext: assert property (p_sext)
        else $error("short load changed the integer value");

    property p_cmpi_less;
        s_op(cbu_pkg::OP_CMPI) ##0 ($signed(SRC1_IN) < $signed(SRC2_IN))
            |=> CC_OUT == cbu_pkg::CC_LESS;
    endproperty
    a_cmpi_less: assert property (p_cmpi_less)
        else $error("integer less did not give code 100");

    property p_concmp_skip;
        s_op(cbu_pkg::OP_CONCMPO) ##0 CC_OUT[2] |=> $stable(CC_OUT);
    endproperty
    a_concmp_skip: assert property (p_concmp_skip)
        else $error("conditional compare altered a set code");

    property p_step_dec;
        s_op(cbu_pkg::OP_CMPDECO) |=>
            RES_WE_OUT && RES_DATA_OUT == $past(SRC2_IN) - 32'h1;
    endproperty
    a_step_dec: assert property (p_step_dec)
        else $error("compare-and-decrement result wrong");

    property p_link;
        s_op(cbu_pkg::OP_BRANCH_LINK) |=>
            s_wrote_reg(cbu_pkg::LINK_GLOBAL_REG) ##0 BRANCH_OUT
            && RES_DATA_OUT == $past(NEXT_IP_IN);
    endproperty
    a_link: assert property (p_link)
        else $error("branch-and-link did not save the return pointer");

    property p_disp_target;
        s_op(cbu_pkg::OP_BRANCH) |=>
            BRANCH_OUT && TARGET_IP_OUT == $past(IP_IN) + $past(DISP_IN);
    endproperty
    a_disp_target: assert property (p_disp_target)
        else $error("displacement target wrong");

    property p_test_true;
        s_op(cbu_pkg::OP_TEST) ##0 ((CC_OUT & COND_SEL_IN) != 3'h0) |=>
            RES_WE_OUT && RES_DATA_OUT == 32'h1;
    endproperty
    a_test_true: assert property (p_test_true)
        else $error("condition test did not store one");

endmodule
`default_nettype wire

// ---- rtl/cbu_pkg.sv ----
// Constants, opcodes and shared helpers of the compare/branch/bit-field unit
package cbu_pkg;

    localparam int WORD_W = 32;
    localparam int CC_SKIP_BIT = 2;
    localparam int RESULT_LATENCY = 1;

    localparam logic [2:0] CC_LESS = 3'h4;
    localparam logic [2:0] CC_EQUAL = 3'h2;
    localparam logic [2:0] CC_GREATER = 3'h1;
    localparam logic [2:0] CC_CLEAR = 3'h0;
    localparam logic [2:0] CC_RESET = 3'h0;

    localparam logic [4:0] LINK_GLOBAL_REG = 5'h1E;
    localparam logic [4:0] REG_RESET = 5'h00;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
    localparam logic [31:0] WORD_ONE = 32'h0000_0001;
    localparam logic [5:0] FIELD_FULL = 6'h20;

    // Operations handled by the unit
    typedef enum logic [4:0] {
        OP_EXTRACT,
        OP_MODIFY,
        OP_SCANBYTE,
        OP_LOAD_SHORT,
        OP_CMPI,
        OP_CMPO,
        OP_CONCMPI,
        OP_CONCMPO,
        OP_CMPINCI,
        OP_CMPINCO,
        OP_CMPDECI,
        OP_CMPDECO,
        OP_BRANCH,
        OP_JUMP_EXTENDED,
        OP_BRANCH_LINK,
        OP_JUMP_EXTENDED_LINK,
        OP_BRANCH_IF,
        OP_CMP_BRANCH_I,
        OP_CMP_BRANCH_O,
        OP_CHECK_BIT_BRANCH,
        OP_TEST
    } cbu_op_e;

    // Selector 000 matches an all-clear code, otherwise any common bit
    function automatic logic cbu_cond_match(input logic [2:0] cc,
                                            input logic [2:0] sel);
        if (sel == CC_CLEAR)
        begin
            return cc == CC_CLEAR;
        end
        return (cc & sel) != CC_CLEAR;
    endfunction

endpackage

// ---- rtl/cbu_ops_if.sv ----
// Operand and result bundle between the core and its datapath slices
`timescale 1ns/1ps
`default_nettype none
interface cbu_ops_if;
    logic [31:0] opa;
    logic [31:0] opb;
    logic [31:0] opc;
    logic is_signed;
    logic [2:0] cmp_cc;
    logic [2:0] scan_cc;
    logic [2:0] bit_cc;
    logic [31:0] extract_val;
    logic [31:0] merge_val;
    logic [31:0] sext_val;

    modport core (output opa, opb, opc, is_signed,
                  input cmp_cc, scan_cc, bit_cc, extract_val, merge_val,
                  sext_val);
    modport cmp (input opa, opb, is_signed, output cmp_cc, scan_cc);
    modport bf (input opa, opb, opc,
                output bit_cc, extract_val, merge_val, sext_val);
endinterface
`default_nettype wire

// ---- rtl/cbu_compare.sv ----
// Magnitude compare and byte-lane scan
`timescale 1ns/1ps
`default_nettype none
module cbu_compare (
    cbu_ops_if.cmp ops
);
    logic lt;
    logic [3:0] lane_eq;

    // Signed or unsigned ordering of opa against opb
    always_comb
    begin
        if (ops.is_signed)
        begin
            lt = $signed(ops.opa) < $signed(ops.opb);
        end
        else
        begin
            lt = ops.opa < ops.opb;
        end
    end

    // Code encoding of the compare result
    assign ops.cmp_cc = (ops.opa == ops.opb) ? cbu_pkg::CC_EQUAL :
                        lt ? cbu_pkg::CC_LESS : cbu_pkg::CC_GREATER;

    // Byte lanes compared pairwise
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            lane_eq[i] = ops.opa[8*i +: 8] == ops.opb[8*i +: 8];
        end
    end

    assign ops.scan_cc = (|lane_eq) ? cbu_pkg::CC_EQUAL
                                    : cbu_pkg::CC_CLEAR;
endmodule
`default_nettype wire

// ---- rtl/cbu_bitfield.sv ----
// Field extract, masked merge, half-word widening and bit check
`timescale 1ns/1ps
`default_nettype none
module cbu_bitfield (
    cbu_ops_if.bf ops
);
    logic [5:0] len;
    logic [32:0] field_mask;

    // Length of 32 or more keeps the whole shifted word
    assign len = (ops.opb[5:0] > cbu_pkg::FIELD_FULL) ? cbu_pkg::FIELD_FULL
                                                       : ops.opb[5:0];
    assign field_mask = (33'h0_0000_0001 << len) - 33'h0_0000_0001;

    // opa = bit position, opb = length, opc = source word
    assign ops.extract_val = (ops.opc >> ops.opa[4:0])
                             & field_mask[31:0];

    // opa = mask, opb = source, opc = old destination
    assign ops.merge_val = (ops.opb & ops.opa)
                           | (ops.opc & ~ops.opa);

    // Half word in opa widened with its sign
    assign ops.sext_val = {{16{ops.opa[15]}}, ops.opa[15:0]};

    // opa = bit index, opb = tested word
    assign ops.bit_cc = ops.opb[ops.opa[4:0]] ? cbu_pkg::CC_EQUAL
                                              : cbu_pkg::CC_CLEAR;
endmodule
`default_nettype wire

// ---- tb/cbu_decode_model.sv ----
// Decode-stage model that hands one operation at a time to the unit
`timescale 1ns/1ps
`default_nettype none
module cbu_decode_model #(
    parameter logic [4:0] DEST_REG = 5'h05
) (
    // Clock
    input wire logic clk_in,
    // Operation request
    output logic op_valid_out,
    output cbu_pkg::cbu_op_e op_code_out,
    output logic [31:0] src1_out,
    output logic [31:0] src2_out,
    output logic [31:0] src3_out,
    output logic [4:0] dest_reg_out,
    output logic [2:0] cond_sel_out,
    // Pointer and addressing
    output logic [31:0] ip_out,
    output logic [31:0] next_ip_out,
    output logic [31:0] disp_out,
    output logic [31:0] ea_out,
    output logic ea_ip_rel_out
);
    // Idle request lines from time zero
    initial
    begin
        {op_valid_out, ea_ip_rel_out, cond_sel_out} = '0;
        op_code_out = cbu_pkg::OP_TEST;
        dest_reg_out = DEST_REG;
        {src1_out, src2_out, src3_out} = '0;
        {ip_out, next_ip_out, disp_out, ea_out} = '0;
    end

    // Launch after a falling edge, hold over the taking rise, then withdraw
    task automatic issue(input cbu_pkg::cbu_op_e op, input logic [31:0] a,
        input logic [31:0] b, input logic [31:0] c, input logic [2:0] s,
        input logic [31:0] ipv, input logic [31:0] dv,
        input logic [31:0] eav, input logic rl);
        @(negedge clk_in);
        op_valid_out = 1'b1;
        op_code_out = op;
        {src1_out, src2_out, src3_out} = {a, b, c};
        cond_sel_out = s;
        {ip_out, disp_out, ea_out} = {ipv, dv, eav};
        next_ip_out = ipv + 32'h4;
        ea_ip_rel_out = rl;
        @(negedge clk_in);
        op_valid_out = 1'b0;
        // Withdrawn operands change so stale values are never reused
        {src1_out, src2_out, src3_out} = ~{src1_out, src2_out, src3_out};
    endtask
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking bench for the compare, branch and bit-field unit
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam logic [4:0] rd = 5'h05;
    localparam logic [31:0] zw = 32'h0;
    logic clk;
    logic rst_n;
    logic op_valid, rel, res_we, br;
    cbu_pkg::cbu_op_e op_code;
    logic [31:0] src1, src2, src3, ip, nip, disp, ea, res_data, tgt;
    logic [4:0] dest, res_reg;
    logic [2:0] sel, cc, cc_exp;
    int err_count = 0;
    int n_tests = 0;
    int cycles = 0;

    // Unit under test
    cbu_top dut (.CLK_IN(clk), .RESETN_IN(rst_n), .OP_VALID_IN(op_valid),
        .OP_CODE_IN(op_code), .SRC1_IN(src1), .SRC2_IN(src2),
        .SRC3_IN(src3), .DEST_REG_IN(dest), .COND_SEL_IN(sel), .IP_IN(ip),
        .NEXT_IP_IN(nip), .DISP_IN(disp), .EA_IN(ea), .EA_IP_REL_IN(rel),
        .RES_WE_OUT(res_we), .RES_REG_OUT(res_reg),
        .RES_DATA_OUT(res_data), .BRANCH_OUT(br), .TARGET_IP_OUT(tgt),
        .CC_OUT(cc));

    // Decode stage
    cbu_decode_model #(.DEST_REG(rd)) dec (.clk_in(clk),
        .op_valid_out(op_valid), .op_code_out(op_code), .src1_out(src1),
        .src2_out(src2), .src3_out(src3), .dest_reg_out(dest),
        .cond_sel_out(sel), .ip_out(ip), .next_ip_out(nip),
        .disp_out(disp), .ea_out(ea), .ea_ip_rel_out(rel));

    // 20 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Cut a hang short
    always @(posedge clk)
    begin
        cycles++;
        if (cycles >= 3000)
        begin
            err_count++;
            give_verdict();
        end
    end

    // Compare one value and count it
    task automatic check(input string name, input logic [31:0] seen,
        input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Condition selector match, worked out independently
    function automatic logic hit(input logic [2:0] c, input logic [2:0] s);
        if (s == 3'h0)
            return c == 3'h0;
        return (c & s) != 3'h0;
    endfunction

    // Issue one operation and judge the cycle after it is taken
    task automatic run(input cbu_pkg::cbu_op_e op, input logic [31:0] a,
        input logic [31:0] b, input logic [31:0] c, input logic [2:0] s,
        input logic [31:0] ipv, input logic [31:0] dv,
        input logic [31:0] eav, input logic rl, input logic we,
        input logic [31:0] data, input logic [4:0] rg, input logic bt,
        input logic [31:0] t);
        dec.issue(op, a, b, c, s, ipv, dv, eav, rl);
        check("write strobe", {31'h0, res_we}, {31'h0, we});
        if (we)
        begin
            check("write index", {27'h0, res_reg}, {27'h0, rg});
            check("write data", res_data, data);
        end
        check("branch", {31'h0, br}, {31'h0, bt});
        if (bt)
            check("target", tgt, t);
        check("cc", {29'h0, cc}, {29'h0, cc_exp});
    endtask

    // Operation without branch fields
    task automatic alu(input cbu_pkg::cbu_op_e op, input logic [31:0] a,
        input logic [31:0] b, input logic [31:0] c, input logic we,
        input logic [31:0] data);
        run(op, a, b, c, 3'h0, zw, zw, zw, 1'b0, we, data, rd, 1'b0, zw);
    endtask

    // Hold reset 16 cycles; outputs are clear at release
    task automatic t_reset();
        rst_n = 1'b0;
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        check("reset cc", {29'h0, cc}, zw);
        check("reset flags", {30'h0, res_we, br}, zw);
        check("reset target", tgt, zw);
        cc_exp = 3'h0;
    endtask

    // Signed, unsigned and conditional compares
    task automatic t_compare();
        cc_exp = 3'h4;
        alu(cbu_pkg::OP_CMPI, 32'hFFFFFFFF, 32'h1, zw, 1'b0, zw);
        cc_exp = 3'h1;
        alu(cbu_pkg::OP_CMPO, 32'hFFFFFFFF, 32'h1, zw, 1'b0, zw);
        cc_exp = 3'h4;
        alu(cbu_pkg::OP_CONCMPI, 32'h1, 32'h2, zw, 1'b0, zw);
        alu(cbu_pkg::OP_CONCMPO, 32'h5, 32'h5, zw, 1'b0, zw);
        cc_exp = 3'h2;
        alu(cbu_pkg::OP_CMPINCI, 32'h5, 32'h5, zw, 1'b1, 32'h6);
        cc_exp = 3'h1;
        alu(cbu_pkg::OP_CMPDECO, 32'h3, zw, zw, 1'b1, 32'hFFFFFFFF);
        cc_exp = 3'h4;
        alu(cbu_pkg::OP_CMPINCO, 32'h1, 32'h2, zw, 1'b1, 32'h3);
        alu(cbu_pkg::OP_CMPDECI, 32'hFFFFFFFF, 32'h1, zw, 1'b1, zw);
    endtask

    // Field extract, merge, widening and byte scan
    task automatic t_bitfield();
        alu(cbu_pkg::OP_EXTRACT, 32'h4, 32'h8, 32'hABCD1234, 1'b1,
            32'h23);
        alu(cbu_pkg::OP_EXTRACT, zw, 32'h20, 32'hDEADBEEF, 1'b1,
            32'hDEADBEEF);
        alu(cbu_pkg::OP_MODIFY, 32'h0000FF00, 32'h12345678, 32'hAAAAAAAA,
            1'b1, 32'hAAAA56AA);
        alu(cbu_pkg::OP_LOAD_SHORT, 32'hABCD8001, zw, zw, 1'b1,
            32'hFFFF8001);
        alu(cbu_pkg::OP_LOAD_SHORT, 32'h12347FFF, zw, zw, 1'b1,
            32'h00007FFF);
        cc_exp = 3'h2;
        alu(cbu_pkg::OP_SCANBYTE, 32'h11223344, 32'h55663377, zw, 1'b0,
            zw);
        // Match in the lowest lane only
        alu(cbu_pkg::OP_SCANBYTE, 32'hA0B0C0D0, 32'h0E0F01D0, zw, 1'b0,
            zw);
    endtask

    // Plain and linking jumps
    task automatic t_branch();
        run(cbu_pkg::OP_BRANCH, zw, zw, zw, 3'h0, 32'h1000, 32'hFFFFFFF0,
            zw, 1'b0, 1'b0, zw, rd, 1'b1, 32'h0FF0);
        run(cbu_pkg::OP_JUMP_EXTENDED, zw, zw, zw, 3'h0, 32'h1000, 32'h40,
            32'h2000, 1'b0, 1'b0, zw, rd, 1'b1, 32'h2000);
        run(cbu_pkg::OP_JUMP_EXTENDED, zw, zw, zw, 3'h0, 32'h1000, 32'h40,
            32'h2000, 1'b1, 1'b0, zw, rd, 1'b1, 32'h1040);
        run(cbu_pkg::OP_BRANCH_LINK, zw, zw, zw, 3'h0, 32'h300, 32'h10, zw,
            1'b0, 1'b1, 32'h304, cbu_pkg::LINK_GLOBAL_REG, 1'b1,
            32'h310);
        run(cbu_pkg::OP_JUMP_EXTENDED_LINK, zw, zw, zw, 3'h0, 32'h700, zw,
            32'h5000, 1'b0, 1'b1, 32'h704, rd, 1'b1, 32'h5000);
    endtask

    // Every selector against less, equal, greater and clear codes
    task automatic t_cond();
        logic m;
        for (int k = 0; k < 4; k++)
        begin
            cc_exp = 3'h4 >> k;
            if (k < 3)
                alu(cbu_pkg::OP_CMPO, 32'h1 + 32'(k), 32'h2, zw, 1'b0,
                    zw);
            else
                alu(cbu_pkg::OP_SCANBYTE, 32'h01020304, 32'h05060708, zw,
                    1'b0, zw);
            for (int s = 0; s < 8; s++)
            begin
                m = hit(cc_exp, 3'(s));
                run(cbu_pkg::OP_BRANCH_IF, zw, zw, zw, 3'(s), 32'h100,
                    32'h20, zw, 1'b0, 1'b0, zw, rd, m, 32'h120);
                run(cbu_pkg::OP_TEST, zw, zw, zw, 3'(s), zw, zw, zw, 1'b0,
                    1'b1, {31'h0, m}, rd, 1'b0, zw);
            end
        end
    endtask

    // Compare-and-branch and bit-test-and-branch on the new code
    task automatic t_cmp_branch();
        cc_exp = 3'h4;
        run(cbu_pkg::OP_CMP_BRANCH_I, 32'hFFFFFFFE, 32'h1, zw, 3'h4,
            32'h200, 32'h8, zw, 1'b0, 1'b0, zw, rd, 1'b1, 32'h208);
        cc_exp = 3'h1;
        run(cbu_pkg::OP_CMP_BRANCH_O, 32'hFFFFFFFE, 32'h1, zw, 3'h4,
            32'h200, 32'h8, zw, 1'b0, 1'b0, zw, rd, 1'b0, zw);
        cc_exp = 3'h2;
        run(cbu_pkg::OP_CHECK_BIT_BRANCH, 32'h3, 32'h8, zw, 3'h2, 32'h400,
            32'h10, zw, 1'b0, 1'b0, zw, rd, 1'b1, 32'h410);
        cc_exp = 3'h0;
        run(cbu_pkg::OP_CHECK_BIT_BRANCH, 32'h2, 32'h8, zw, 3'h2, 32'h400,
            32'h10, zw, 1'b0, 1'b0, zw, rd, 1'b0, zw);
    endtask

    // Print counts and the verdict, then stop
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Main sequence, with a reset in mid-run before a last conditional compare
    initial
    begin
        t_reset();
        t_compare();
        t_bitfield();
        t_branch();
        t_cond();
        t_cmp_branch();
        // Unused operation code: no write, no branch, code held
        alu(cbu_pkg::cbu_op_e'(5'h1F), 32'h1, 32'h2, zw, 1'b0, zw);
        cc_exp = 3'h4;
        alu(cbu_pkg::OP_CMPI, 32'h1, 32'h2, zw, 1'b0, zw);
        t_reset();
        // Reset clears bit 2, so a conditional compare runs again
        cc_exp = 3'h1;
        alu(cbu_pkg::OP_CONCMPO, 32'h9, 32'h2, zw, 1'b0, zw);
        give_verdict();
    end
endmodule
`default_nettype wire
